// [design/sfw_pkg.sv]
// Purpose: Shared constants and types for the SPI frame watchdog link
// Assumes: 100 MHz system clock on both ends
// Notes:   Address 0x00 is reserved as the dummy lead byte of long frames
package sfw_pkg;
    // Timing
    localparam int CLK_NS      = 10;
    localparam int MS_NS       = 1000000;
    localparam int CYC_PER_MS  = MS_NS / CLK_NS;
    localparam int WD_SHORT_MS = 50;
    localparam int WD_LONG_MS  = 200;
    localparam logic [2:0] SCLK_HALF_CYC = 3'h6;

    // Frame format
    localparam logic [5:0] BITS_24    = 6'h18;
    localparam logic [5:0] BITS_32    = 6'h20;
    localparam logic [5:0] BYTE1_LAST = 6'h07;
    localparam logic [5:0] BYTE2_LAST = 6'h0f;
    localparam logic [7:0] DUMMY_BYTE = 8'h00;
    localparam int         WRITE_POS  = 7;

    // Device register addresses
    localparam logic [6:0] ADDR_GEN1   = 7'h01;
    localparam logic [6:0] ADDR_GEN2   = 7'h02;
    localparam logic [6:0] ADDR_BRIDGE = 7'h03;

    // general_control_first fields
    localparam int TOGGLE_POS = 0;
    localparam int LONG_POS   = 1;
    localparam int UNLOCK_POS = 2;
    localparam int GAIN_LSB   = 3;
    localparam logic [15:0] GEN1_RESET = 16'h0000;

    // general_control_second fields
    localparam int OFF_POS   = 0;
    localparam int CLRFS_POS = 1;

    // Global status byte fields
    localparam int ST_FS_POS   = 7;
    localparam int ST_WDEN_POS = 6;
    localparam int ST_UNLK_POS = 5;
    localparam int ST_FERR_POS = 0;

    // Host APB map
    localparam logic [11:0] OFS_TX   = 12'h000;
    localparam logic [11:0] OFS_CTRL = 12'h004;
    localparam logic [11:0] OFS_STAT = 12'h008;
    localparam logic [11:0] OFS_RX   = 12'h00c;
    localparam int CTRL_LONG_POS = 0;
    localparam int CTRL_GO_POS   = 1;
    localparam int STAT_BUSY_POS = 0;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_LEAD = 3'h1,
        H_HIGH = 3'h3,
        H_LOW  = 3'h2,
        H_TAIL = 3'h6,
        H_GAP  = 3'h7
    } sfw_hstate_e;
endpackage

// [design/sfw_link_if.sv]
// Purpose: Serial link between host master and device slave
// Assumes: Data line idles high when the device does not drive it
// Notes:   Resolves the device output enable into the line level
`timescale 1ns/1ps
interface sfw_link_if;
    logic sclk;
    logic csN;
    logic mosi;
    logic miso;
    logic misoOe;
    logic misoLine;

    assign misoLine = misoOe ? miso : 1'b1;

    modport device (input sclk, input csN, input mosi, output miso, output misoOe);
    modport host   (output sclk, output csN, output mosi, input misoLine);
endinterface

// [design/sfw_sync.sv]
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
module sfw_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    import sfw_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sfw_sync_s;

    sfw_sync_s s_r;
    sfw_sync_s s_nxt;

    always_comb begin
        s_nxt.meta = d;
        s_nxt.sync = s_r.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q = s_r.sync;
endmodule // sfw_sync

// [design/sfw_device.sv]
// Purpose: Slave end: frame decode, status reply and host watchdog
// Assumes: Link clock idles low, data taken on rising edge
// Notes:   A zero first byte marks a long frame; address 0 is never used
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Contract
// - Native frame is 24 bits: address, data
// - Long frame: zero byte, address, two data bytes
// - Long reply: status, zero byte, response word
// - Host sends zero as the extra lead byte
// - Watchdog supervises host traffic
// - Watchdog active straight after reset
// - Host may switch watchdog on or off
// - Timeout 50 or 200 ms, then failure
// - Failure enters fail-safe, all gates off
// - Each first-register write must invert toggle bit
// - Toggle rule holds for unrelated field writes
// - Drive stops on permit low or sleep
// - Toggle bit reads zero after reset
// - Unlock write then next frame disables
// - Intervening frame clears unlock, disable ignored
module sfw_device #(
    parameter int MsCycles = sfw_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Link
    sfw_link_if.device      link,
    // Drive control
    input  wire logic       drivePermit,
    input  wire logic       sleepReq,
    output logic [7:0]      gateOn,
    // Watchdog state
    output logic            failSafe,
    output logic            wdActive
);
    import sfw_pkg::*;

    typedef struct packed {
        logic        csPrev;
        logic        sclkPrev;
        logic [5:0]  bitCnt;
        logic        dummy;
        logic [23:0] inSh;
        logic [23:0] outSh;
        logic        miso;
        logic        misoOe;
        logic [15:0] gen1;
        logic [7:0]  bridge;
        logic        unlock;
        logic        wdEn;
        logic        fs;
        logic        ferr;
        logic [16:0] tickCnt;
        logic [7:0]  msCnt;
        logic [7:0]  gate;
    } sfw_dev_s;

    localparam sfw_dev_s DEV_RST = '{csPrev: 1'b1, wdEn: 1'b1, gen1: GEN1_RESET, default: '0};

    sfw_dev_s   s_r;
    sfw_dev_s   s_nxt;
    logic [3:0] syncQ;
    logic       sclkS;
    logic       csS;
    logic       mosiS;
    logic       permitS;

    // Pins cross into the system clock here
    // Select enters inverted so the zero reset of the stages reads as idle, not as a frame
    sfw_sync #(.W(4)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({link.sclk, !link.csN, link.mosi, drivePermit}),
        .q     (syncQ)
    );
    assign {sclkS, csS, mosiS, permitS} = {syncQ[3], !syncQ[2], syncQ[1:0]};

    function automatic logic [15:0] respWord(input sfw_dev_s st, input logic [7:0] a);
        logic [15:0] w;
        w = 16'h0000;
        case (a[6:0])
            ADDR_GEN1: begin
                w = st.gen1;
                w[UNLOCK_POS] = st.unlock;
            end
            ADDR_GEN2: w[OFF_POS] = !st.wdEn;
            ADDR_BRIDGE: w = {8'h00, st.bridge};
            default: w = 16'h0000;
        endcase
        return w;
    endfunction

    always_comb begin
        logic [7:0]  status;
        logic [7:0]  firstByte;
        logic [7:0]  addr;
        logic [15:0] data;
        logic        valid;
        logic        kick;
        logic [7:0]  limit;
        s_nxt     = s_r;
        status    = 8'h00;
        firstByte = {s_r.inSh[6:0], mosiS};
        addr      = s_r.inSh[23:16];
        data      = s_r.inSh[15:0];
        valid     = 1'b0;
        kick      = 1'b0;
        limit     = s_r.gen1[LONG_POS] ? 8'(WD_LONG_MS) : 8'(WD_SHORT_MS);
        status[ST_FS_POS]   = s_r.fs;
        status[ST_WDEN_POS] = s_r.wdEn;
        status[ST_UNLK_POS] = s_r.unlock;
        status[ST_FERR_POS] = s_r.ferr;
        s_nxt.csPrev   = csS;
        s_nxt.sclkPrev = sclkS;

        if (!csS && s_r.csPrev) begin
            s_nxt.bitCnt = 6'h00;
            s_nxt.dummy  = 1'b0;
            s_nxt.outSh  = {status, 16'h0000};
        end else if (!csS && sclkS && !s_r.sclkPrev) begin
            s_nxt.inSh = {s_r.inSh[22:0], mosiS};
            if (s_r.bitCnt != 6'h3f) begin
                s_nxt.bitCnt = s_r.bitCnt + 6'h01;
            end
            if (s_r.bitCnt == BYTE1_LAST) begin
                if (firstByte == DUMMY_BYTE) begin
                    s_nxt.dummy = 1'b1;
                end else begin
                    s_nxt.outSh = {s_r.outSh[23], respWord(s_r, firstByte), 7'h00};
                end
            end
            if (s_r.bitCnt == BYTE2_LAST && s_r.dummy) begin
                s_nxt.outSh = {s_r.outSh[23], respWord(s_r, firstByte), 7'h00};
            end
        end else if (!csS && !sclkS && s_r.sclkPrev) begin
            s_nxt.outSh = {s_r.outSh[22:0], 1'b0};
        end

        // Frame end: only exact lengths are acted on
        if (csS && !s_r.csPrev) begin
            valid = (s_r.bitCnt == BITS_24 && !s_r.dummy) || (s_r.bitCnt == BITS_32 && s_r.dummy);
            s_nxt.ferr   = !valid;
            s_nxt.unlock = 1'b0;
            if (valid && addr[WRITE_POS]) begin
                case (addr[6:0])
                    ADDR_GEN1: begin
                        if (data[TOGGLE_POS] == s_r.gen1[TOGGLE_POS]) begin
                            s_nxt.fs = 1'b1;
                        end else begin
                            s_nxt.gen1   = data;
                            s_nxt.unlock = data[UNLOCK_POS];
                            kick         = 1'b1;
                        end
                    end
                    ADDR_GEN2: begin
                        if (data[OFF_POS] && s_r.unlock) begin
                            s_nxt.wdEn = 1'b0;
                        end else if (!data[OFF_POS]) begin
                            s_nxt.wdEn = 1'b1;
                            kick       = 1'b1;
                        end
                        if (data[CLRFS_POS]) begin
                            s_nxt.fs = 1'b0;
                        end
                    end
                    ADDR_BRIDGE: s_nxt.bridge = data[7:0];
                    default: s_nxt.bridge = s_nxt.bridge;
                endcase
            end
        end

        // Timeout runs only while supervising
        if (kick || !s_r.wdEn || s_r.fs) begin
            s_nxt.tickCnt = 17'h00000;
            s_nxt.msCnt   = 8'h00;
        end else if (s_r.tickCnt == 17'(MsCycles - 1)) begin
            s_nxt.tickCnt = 17'h00000;
            s_nxt.msCnt   = s_r.msCnt + 8'h01;
            if (s_r.msCnt + 8'h01 == limit) begin
                s_nxt.fs = 1'b1;
            end
        end else begin
            s_nxt.tickCnt = s_r.tickCnt + 17'h00001;
        end

        // Bridge command is dropped so drive never resumes on its own
        if (s_nxt.fs && !s_r.fs) begin
            s_nxt.bridge = 8'h00;
        end
        s_nxt.gate   = (s_nxt.fs || !permitS || sleepReq) ? 8'h00 : s_nxt.bridge;
        s_nxt.misoOe = !csS;
        s_nxt.miso   = s_nxt.outSh[23];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= DEV_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign gateOn      = s_r.gate;
    assign failSafe    = s_r.fs;
    assign wdActive    = s_r.wdEn;
    assign link.miso   = s_r.miso;
    assign link.misoOe = s_r.misoOe;
endmodule // sfw_device

// [design/sfw_host.sv]
// Purpose: Master end: APB-programmed frame engine
// Assumes: Software builds toggle and unlock values itself
// Notes:   Link clock is the system clock divided by twice the half count
`timescale 1ns/1ps
module sfw_host (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Link
    sfw_link_if.host         link
);
    import sfw_pkg::*;

    typedef struct packed {
        logic [23:0] txw;
        logic        longF;
        logic        busy;
        logic [31:0] rx;
        logic [31:0] sh;
        logic [5:0]  bitCnt;
        logic [5:0]  bits;
        logic [2:0]  half;
        sfw_hstate_e st;
        logic        sclk;
        logic        csN;
        logic        mosi;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sfw_host_s;

    localparam sfw_host_s HOST_RST = '{csN: 1'b1, st: H_IDLE, default: '0};

    sfw_host_s s_r;
    sfw_host_s s_nxt;
    logic      misoS;

    sfw_sync #(.W(1)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (link.misoLine),
        .q     (misoS)
    );

    always_comb begin
        logic halfDone;
        logic go;
        s_nxt    = s_r;
        go       = 1'b0;
        halfDone = (s_r.half == SCLK_HALF_CYC - 3'h1);
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;

        // One wait state, then a registered answer
        if (psel && penable && !s_r.pready) begin
            s_nxt.pready = 1'b1;
            s_nxt.prdata = 32'h00000000;
            case (paddr)
                OFS_TX:   s_nxt.prdata = {8'h00, s_r.txw};
                OFS_CTRL: s_nxt.prdata[CTRL_LONG_POS] = s_r.longF;
                OFS_STAT: s_nxt.prdata[STAT_BUSY_POS] = s_r.busy;
                OFS_RX:   s_nxt.prdata = s_r.rx;
                default:  s_nxt.pslverr = 1'b1;
            endcase
        end

        // Writes land only on the edge that completes the transfer
        if (psel && penable && s_r.pready && pwrite) begin
            case (paddr)
                OFS_TX: begin
                    if (!s_r.busy) begin
                        s_nxt.txw = pwdata[23:0];
                    end
                end
                OFS_CTRL: begin
                    s_nxt.longF = pwdata[CTRL_LONG_POS];
                    go          = pwdata[CTRL_GO_POS] && !s_r.busy;
                end
                default: go = 1'b0;
            endcase
        end

        s_nxt.half = halfDone ? 3'h0 : s_r.half + 3'h1;
        case (s_r.st)
            H_IDLE: begin
                s_nxt.half = 3'h0;
                if (go) begin
                    // Long frame leads with the zero byte
                    s_nxt.sh     = s_nxt.longF ? {DUMMY_BYTE, s_r.txw} : {s_r.txw, 8'h00};
                    s_nxt.bits   = s_nxt.longF ? BITS_32 : BITS_24;
                    s_nxt.bitCnt = 6'h00;
                    s_nxt.rx     = 32'h00000000;
                    s_nxt.busy   = 1'b1;
                    s_nxt.csN    = 1'b0;
                    s_nxt.mosi   = s_nxt.sh[31];
                    s_nxt.st     = H_LEAD;
                end
            end
            H_LEAD, H_LOW: begin
                if (halfDone) begin
                    s_nxt.sclk = 1'b1;
                    s_nxt.st   = H_HIGH;
                end
            end
            H_HIGH: begin
                if (halfDone) begin
                    s_nxt.rx     = {s_r.rx[30:0], misoS};
                    s_nxt.sclk   = 1'b0;
                    s_nxt.sh     = {s_r.sh[30:0], 1'b0};
                    s_nxt.mosi   = s_r.sh[30];
                    s_nxt.bitCnt = s_r.bitCnt + 6'h01;
                    s_nxt.st     = (s_r.bitCnt + 6'h01 == s_r.bits) ? H_TAIL : H_LOW;
                end
            end
            H_TAIL: begin
                if (halfDone) begin
                    s_nxt.csN = 1'b1;
                    s_nxt.st  = H_GAP;
                end
            end
            H_GAP: begin
                if (halfDone) begin
                    s_nxt.busy = 1'b0;
                    s_nxt.st   = H_IDLE;
                end
            end
            default: s_nxt.st = H_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= HOST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata    = s_r.prdata;
    assign pready    = s_r.pready;
    assign pslverr   = s_r.pslverr;
    assign link.sclk = s_r.sclk;
    assign link.csN  = s_r.csN;
    assign link.mosi = s_r.mosi;
endmodule // sfw_host

// [sim/sfw_asserts.sv]
// Purpose: Link and output checks between the host and device ends
// Assumes: One clock domain; the link is sampled by clk
// Notes:   The bit counter clears while the frame select is high
`timescale 1ns/1ps
module sfw_asserts (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Link
    input  wire logic       sclk,
    input  wire logic       csN,
    input  wire logic       mosi,
    input  wire logic       miso,
    input  wire logic       misoOe,
    input  wire logic       misoLine,
    // Device outputs
    input  wire logic [7:0] gateOn,
    input  wire logic       failSafe
);
    logic [5:0] bitCnt_r;
    logic       sclkQ_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Counts link clock rises inside one frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt_r <= 6'h00;
            sclkQ_r  <= 1'b0;
        end else begin
            sclkQ_r  <= sclk;
            bitCnt_r <= csN ? 6'h00 : bitCnt_r + {5'h00, sclk && !sclkQ_r};
        end
    end

    sequence highPhase;
        sclk [*6] ##1 !sclk;
    endsequence
    sequence leadIn;
        !sclk [*3] ##[1:6] sclk;
    endsequence

    sclk_idle_a:   assert property (csN |-> !sclk) else $error("link clock moves outside a frame");
    sclk_high_a:   assert property ($rose(sclk) |-> highPhase) else $error("link clock high phase wrong");
    sclk_low_a:    assert property ($fell(sclk) |-> !sclk [*6]) else $error("link clock low phase short");
    lead_in_a:     assert property ($fell(csN) |-> leadIn) else $error("frame lead-in wrong");
    mosi_hold_a:   assert property (sclk && $past(sclk) |-> $stable(mosi)) else $error("host data moved");
    frame_len_a:   assert property ($rose(csN) |-> bitCnt_r inside {6'd24, 6'd32}) else $error("bad bit count");
    reply_on_a:    assert property ($fell(csN) |-> ##[1:6] misoOe) else $error("reply not driven");
    miso_hold_a:   assert property (sclk && $past(sclk) |-> $stable(misoLine)) else $error("reply data moved");
    gates_off_a:   assert property (failSafe |-> gateOn == 8'h00) else $error("gates on in fail-safe");
endmodule // sfw_asserts

// [sim/test_spi_frame_watchdog.sv]
// Purpose: Self-checking bench for the SPI frame watchdog link
// Assumes: Host end programmed over APB, device end faces it
// Notes:   Short ms parameter keeps timeouts to a few thousand cycles
`timescale 1ns/1ps
module test_spi_frame_watchdog;
    import sfw_pkg::*;
    localparam int MS = 20;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic        drivePermit, sleepReq, failSafe, wdActive;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  gateOn, bridge;
    logic [1:0]  gain;
    logic        tgl, lng, unl, fs, wdEn, ferr;
    int          mismatches, total_checks, cyc;

    sfw_link_if link();
    sfw_host i_sfw_host (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    sfw_device #(.MsCycles(MS)) i_sfw_device (.clk(clk), .rst_n(rst_n), .link(link),
        .drivePermit(drivePermit), .sleepReq(sleepReq), .gateOn(gateOn), .failSafe(failSafe), .wdActive(wdActive));
    sfw_asserts u_chk (.clk(clk), .rst_n(rst_n), .sclk(link.sclk), .csN(link.csN), .mosi(link.mosi),
        .miso(link.miso), .misoOe(link.misoOe), .misoLine(link.misoLine), .gateOn(gateOn), .failSafe(failSafe));

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic checkRx(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
        total_checks++;
        if ((got & msk) !== (exp & msk)) begin
            mismatches++;
            $display("mismatch at %0t: word %h expected %h", $time, got & msk, exp & msk);
        end
    endtask

    task automatic checkPins();
        logic [9:0] e;
        e = {fs, wdEn, (fs || !drivePermit || sleepReq) ? 8'h00 : bridge};
        total_checks++;
        if ({failSafe, wdActive, gateOn} !== e) begin
            mismatches++;
            $display("mismatch at %0t: pins %h expected %h", $time, {failSafe, wdActive, gateOn}, e);
        end
    endtask

    // Holds the request until pready is seen, then releases for one cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No cycle count assumed; only the bench timeout ends a stuck wait
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic frame(input logic lg, input logic [7:0] ab, input logic [15:0] dat);
        logic [31:0] q, x, m;
        logic [15:0] rs, mk;
        logic        e, uo;
        int          n;
        rs = 16'h0000;
        mk = 16'h0000;
        if (ab[6:0] == ADDR_GEN1) begin
            rs = {11'h000, gain, 1'b0, lng, tgl};
            mk = 16'h001b;
        end else if (ab[6:0] == ADDR_GEN2) begin
            rs = {15'h0000, !wdEn};
            mk = 16'h0001;
        end else if (ab[6:0] == ADDR_BRIDGE) begin
            rs = {8'h00, bridge};
            mk = 16'h00ff;
        end
        x = lg ? {fs, wdEn, unl, 4'h0, ferr, 8'h00, rs} : {8'h00, fs, wdEn, unl, 4'h0, ferr, rs};
        m = lg ? {16'hffff, mk} : {16'h00ff, mk};
        apb(1'b1, OFS_TX, {8'h00, ab, dat}, q, e);
        apb(1'b1, OFS_CTRL, {30'h0, 1'b1, lg}, q, e);
        n = 0;
        do begin
            apb(1'b0, OFS_STAT, 32'h0, q, e);
            n++;
        end while (q[STAT_BUSY_POS] !== 1'b0 && n < 200);
        apb(1'b0, OFS_RX, 32'h0, q, e);
        checkRx(q, x, m);
        uo   = unl;
        unl  = 1'b0;
        ferr = !lg && ab == 8'h00;
        if (!ferr && ab[WRITE_POS]) begin
            if (ab[6:0] == ADDR_GEN1 && dat[TOGGLE_POS] === tgl) begin
                fs     = 1'b1;
                bridge = 8'h00;
            end else if (ab[6:0] == ADDR_GEN1) begin
                tgl  = dat[TOGGLE_POS];
                lng  = dat[LONG_POS];
                unl  = dat[UNLOCK_POS];
                gain = dat[GAIN_LSB+:2];
            end else if (ab[6:0] == ADDR_GEN2) begin
                wdEn = dat[OFF_POS] ? wdEn && !uo : 1'b1;
                fs   = fs && !dat[CLRFS_POS];
            end else if (ab[6:0] == ADDR_BRIDGE) begin
                bridge = dat[7:0];
            end
        end
        repeat (4) @(posedge clk);
        checkPins();
    endtask

    task automatic kick(input logic lg, input logic u, input logic l);
        frame(lg, 8'h81, {11'h000, 2'($urandom), u, l, !tgl});
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        logic [31:0] q;
        logic        e;
        {rst_n, psel, penable, pwrite, paddr, pwdata, sleepReq} = '0;
        {tgl, lng, unl, fs, ferr, gain, bridge, mismatches, total_checks, cyc} = '0;
        wdEn = 1'b1;
        drivePermit = 1'b1;
        void'($urandom(20642));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        checkPins();
        apb(1'b0, 12'h010, 32'h0, q, e);
        checkRx({31'h0, e}, 32'h1, 32'h1);
        frame(1'b0, 8'h01, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            kick(i[0], 1'b0, 1'b0);
            drivePermit <= 1'($urandom);
            sleepReq    <= 1'($urandom);
            frame(!i[0], 8'h83, 16'($urandom));
        end
        frame(1'b0, 8'h81, {11'h000, gain, 1'b0, lng, tgl});
        frame(1'b1, 8'h82, 16'h0002);
        kick(1'b0, 1'b0, 1'b0);
        repeat (WD_SHORT_MS * MS - 50) @(posedge clk);
        checkPins();
        repeat (100) @(posedge clk);
        fs = 1'b1;
        bridge = 8'h00;
        checkPins();
        frame(1'b0, 8'h82, 16'h0002);
        kick(1'b1, 1'b0, 1'b1);
        repeat (WD_LONG_MS * MS - 50) @(posedge clk);
        checkPins();
        repeat (100) @(posedge clk);
        fs = 1'b1;
        checkPins();
        frame(1'b0, 8'h82, 16'h0002);
        // Unlock broken by a frame in between, then unlock followed straight by disable
        kick(1'b0, 1'b1, 1'b1);
        frame(1'b1, 8'h03, 16'h0000);
        frame(1'b0, 8'h82, 16'h0001);
        kick(1'b1, 1'b1, 1'b1);
        frame(1'b0, 8'h00, 16'h0000);
        frame(1'b0, 8'h82, 16'h0001);
        kick(1'b0, 1'b1, 1'b1);
        frame(1'b1, 8'h82, 16'h0001);
        repeat (WD_LONG_MS * MS + 200) @(posedge clk);
        checkPins();
        frame(1'b0, 8'h82, 16'h0000);
        kick(1'b0, 1'b0, 1'b1);
        final_report();
    end
endmodule // test_spi_frame_watchdog
